// ### rtl/shared_link_pkg.sv
package shared_link_pkg;
    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [15:0] SETUP_ADDR  = 16'h19F5;  // serial_port_setup_word
    localparam logic [15:0] STATUS_ADDR = 16'h0040;  // link status, read only
    localparam logic [15:0] AREA_BASE   = 16'h0000;  // shared_link_word_area, 64 words
    localparam int          AREA_WORDS  = 64;
    localparam logic [15:0] SETUP_RESET = 16'h0000;  // link off until configured

    // ****************************************************************
    // setup word fields
    // ****************************************************************
    localparam int         MODE_LSB    = 12;
    localparam int         RANGE_LSB   = 8;
    localparam logic [3:0] MODE_MASTER = 4'h3;
    localparam logic [3:0] MODE_SLAVE  = 4'h2;
    localparam logic [3:0] RANGE_64    = 4'h0;
    localparam logic [3:0] RANGE_32    = 4'h1;
    localparam logic [3:0] RANGE_16    = 4'h2;

    // ****************************************************************
    // status word fields
    // ****************************************************************
    localparam int ST_RANGE_LSB = 0;
    localparam int ST_SLAVE     = 2;
    localparam int ST_MASTER    = 3;
    localparam int ST_LINK_UP   = 15;

    // ****************************************************************
    // serial link timing and frame
    // ****************************************************************
    localparam int         CLK_NS      = 8;
    localparam int         LINK_BIT_NS = 128;
    localparam logic [7:0] BIT_CYC     = 8'(LINK_BIT_NS / CLK_NS);
    localparam logic [7:0] HALF_CYC    = 8'(LINK_BIT_NS / CLK_NS / 2);
    localparam logic [4:0] FRAME_BITS  = 5'h1A;      // start, 24 payload, stop
    localparam logic [4:0] RX_STOP_IDX = 5'h19;
endpackage

// ### rtl/peer_shared_word_link.sv
`timescale 1ns/1ns
// What this block does
// - a word written locally is copied to the same word at the partner automatically
// - in master or slave mode software writes only its own half; partner half is updated by the link only
// - one side is set master and the other slave by the mode nibble
// - only mode and range are configured; range comes from master, slave ignores it
// - range field sits in bits 8 to 11, meaningful only in master mode
// - area splits in halves: 64 words gives 0-31/32-63, 16 gives 0-7/8-15
// - setup word 3200 selects master with a 16-word shared area
// - setup word 2000 selects slave; the other fields are ignored
// - once configured the link exchanges words by itself, no start command
module peer_shared_word_link (
    // clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rst_b_i,
    // register port
    input  wire logic [15:0] reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [15:0] reg_rdata_o,
    // serial link to the partner
    input  wire logic        link_rx_i,
    output logic             link_tx_o,
    output logic             link_up_o
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [63:0][15:0] mem;
        logic [15:0]       setup;
        logic [15:0]       rdata;
        logic [25:0]       tx_sh;
        logic [4:0]        tx_left;
        logic [7:0]        tx_tim;
        logic [5:0]        tx_idx;
        logic              rx_m;
        logic              rx_s;
        logic              rx_busy;
        logic [7:0]        rx_tim;
        logic [4:0]        rx_cnt;
        logic [23:0]       rx_sh;
        logic [1:0]        rx_range;
        logic              link_up;
    } state_s;

    state_s st;
    state_s next_st;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // half of the area in words for a range code
    function automatic logic [6:0] half_of(input logic [1:0] r);
        half_of = 7'h20 >> r;
    endfunction

    // true when word a belongs to the side given by m (1 = master)
    function automatic logic owns(input logic [5:0] a, input logic m, input logic [1:0] r);
        logic [6:0] h;
        h = half_of(r);
        if (m) begin
            owns = {1'b0, a} < h;
        end else begin
            owns = ({1'b0, a} >= h) && ({1'b0, a} < (h << 1));
        end
    endfunction

    logic [3:0] mode;
    logic [3:0] rng_field;
    logic       is_master;
    logic       is_slave;
    logic [1:0] eff_range;
    logic [5:0] own_base;
    logic [6:0] half_w;

    // mode decode; range field only counts on the master
    always_comb begin
        mode      = st.setup[shared_link_pkg::MODE_LSB +: 4];
        rng_field = st.setup[shared_link_pkg::RANGE_LSB +: 4];
        is_master = (mode == shared_link_pkg::MODE_MASTER);
        is_slave  = (mode == shared_link_pkg::MODE_SLAVE);
        if (is_master) begin
            if (rng_field == shared_link_pkg::RANGE_16) begin
                eff_range = 2'h2;
            end else if (rng_field == shared_link_pkg::RANGE_32) begin
                eff_range = 2'h1;
            end else begin
                eff_range = 2'h0;                                // 64 words, also unused codes 3 to 15
            end
        end else begin
            eff_range = st.rx_range;
        end
        // a function result cannot be sliced, so the half is held first
        half_w   = half_of(eff_range);
        own_base = is_master ? 6'h00 : half_w[5:0];
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    logic [5:0]  loc_a;
    logic [5:0]  rx_a;
    logic [5:0]  nxt_idx;
    logic [23:0] pay;

    always_comb begin
        next_st = st;
        loc_a   = reg_addr_i[5:0];
        rx_a    = st.rx_sh[21:16];
        nxt_idx = 6'h00;
        pay     = 24'h000000;

        // register writes; partner words refuse software writes when linked
        if (reg_wr_i) begin
            if (reg_addr_i == shared_link_pkg::SETUP_ADDR) begin
                next_st.setup = reg_wdata_i;
            end else if (reg_addr_i < shared_link_pkg::AREA_BASE + 16'(shared_link_pkg::AREA_WORDS)) begin
                if (!(is_master || is_slave) || owns(loc_a, is_master, eff_range)) begin
                    next_st.mem[loc_a] = reg_wdata_i;
                end
            end
        end

        // register reads, data stand in the next cycle only
        next_st.rdata = 16'h0000;
        if (reg_rd_i) begin
            if (reg_addr_i == shared_link_pkg::SETUP_ADDR) begin
                next_st.rdata = st.setup;
            end else if (reg_addr_i == shared_link_pkg::STATUS_ADDR) begin
                next_st.rdata[shared_link_pkg::ST_RANGE_LSB +: 2] = eff_range;
                next_st.rdata[shared_link_pkg::ST_SLAVE]          = is_slave;
                next_st.rdata[shared_link_pkg::ST_MASTER]         = is_master;
                next_st.rdata[shared_link_pkg::ST_LINK_UP]        = st.link_up;
            end else if (reg_addr_i < shared_link_pkg::AREA_BASE + 16'(shared_link_pkg::AREA_WORDS)) begin
                next_st.rdata = st.mem[loc_a];
            end
        end

        // transmitter: cycles through own words forever, so every write to an own word
        // reaches the partner without any start command
        if (st.tx_left == 5'h00) begin
            if (is_master || is_slave) begin
                pay     = {eff_range, st.tx_idx, st.mem[st.tx_idx]};
                next_st.tx_sh   = {1'b1, pay, 1'b0};
                next_st.tx_left = shared_link_pkg::FRAME_BITS;
                next_st.tx_tim  = shared_link_pkg::BIT_CYC - 8'h01;
                nxt_idx = st.tx_idx + 6'h01;
                if (!owns(nxt_idx, is_master, eff_range)) begin
                    nxt_idx = own_base;
                end
                next_st.tx_idx = nxt_idx;
            end else begin
                next_st.tx_idx = 6'h00;
            end
        end else if (st.tx_tim == 8'h00) begin
            next_st.tx_sh   = {1'b1, st.tx_sh[25:1]};            // idle line is high
            next_st.tx_left = st.tx_left - 5'h01;
            next_st.tx_tim  = shared_link_pkg::BIT_CYC - 8'h01;
        end else begin
            next_st.tx_tim = st.tx_tim - 8'h01;
        end
        // a stale index after a range change is pulled back into own half
        if (st.tx_left == 5'h00 && (is_master || is_slave)
            && !owns(st.tx_idx, is_master, eff_range)) begin
            next_st.tx_idx = own_base;
            next_st.tx_sh  = st.tx_sh;
            next_st.tx_left = 5'h00;
        end

        // receiver; only the second sync stage is looked at
        next_st.rx_m = link_rx_i;
        next_st.rx_s = st.rx_m;
        if (!st.rx_busy) begin
            if (!st.rx_s) begin
                next_st.rx_busy = 1'b1;
                next_st.rx_cnt  = 5'h00;
                next_st.rx_tim  = shared_link_pkg::HALF_CYC - 8'h01;
            end
        end else if (st.rx_tim != 8'h00) begin
            next_st.rx_tim = st.rx_tim - 8'h01;
        end else begin
            next_st.rx_tim = shared_link_pkg::BIT_CYC - 8'h01;
            next_st.rx_cnt = st.rx_cnt + 5'h01;
            if (st.rx_cnt == 5'h00) begin
                next_st.rx_busy = ~st.rx_s;                      // glitch, not a start bit
            end else if (st.rx_cnt < shared_link_pkg::RX_STOP_IDX) begin
                next_st.rx_sh = {st.rx_s, st.rx_sh[23:1]};
            end else begin
                next_st.rx_busy = 1'b0;
                if (st.rx_s && (is_master || is_slave)) begin
                    next_st.link_up = 1'b1;
                    if (is_slave) begin
                        next_st.rx_range = st.rx_sh[23:22];
                    end
                    // only partner words are taken from the link
                    if (!owns(rx_a, is_master, eff_range)
                        && ({1'b0, rx_a} < (half_of(eff_range) << 1))) begin
                        next_st.mem[rx_a] = st.rx_sh[15:0];
                    end
                end
            end
        end
        // drop link up in the same cycle the setup word leaves link mode,
        // so a frame committing beside that write cannot hold it up
        if ((next_st.setup[shared_link_pkg::MODE_LSB +: 4] != shared_link_pkg::MODE_MASTER)
            && (next_st.setup[shared_link_pkg::MODE_LSB +: 4] != shared_link_pkg::MODE_SLAVE)) begin
            next_st.link_up = 1'b0;
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            st          <= '0;
            st.setup    <= shared_link_pkg::SETUP_RESET;
            st.tx_sh    <= '1;
            st.rx_m     <= 1'b1;
            st.rx_s     <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from flops
    assign reg_rdata_o = st.rdata;
    assign link_tx_o   = st.tx_sh[0];
    assign link_up_o   = st.link_up;
endmodule

// ### tb/peer_shared_word_link_sva.sv
`timescale 1ns/1ns
module peer_shared_word_link_chk (
    // clock, reset, register port
    input wire logic        core_clk_i,
    input wire logic        rst_b_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    // serial side
    input wire logic        link_tx_o,
    input wire logic        link_up_o
);
    // ********
    // setup shadow
    // ********
    logic [15:0] setup;
    logic [8:0]  off_cnt;
    logic        is_m;
    logic        is_s;
    logic [1:0]  code;
    logic        wr_su;
    logic        rd_st;
    assign is_m  = setup[15:12] == 4'h3;
    assign is_s  = setup[15:12] == 4'h2;
    assign code  = setup[11:8] == 4'h1 ? 2'h1 : setup[11:8] == 4'h2 ? 2'h2 : 2'h0;
    assign wr_su = reg_wr_i && reg_addr_i == shared_link_pkg::SETUP_ADDR;
    assign rd_st = reg_rd_i && reg_addr_i == shared_link_pkg::STATUS_ADDR;
    // saturating count, longer than one frame so a frame in flight may finish
    always_ff @(posedge core_clk_i) begin
        setup   <= !rst_b_i ? 16'h0000 : wr_su ? reg_wdata_i : setup;
        off_cnt <= (!rst_b_i || is_m || is_s) ? 9'h000 : off_cnt + 9'(off_cnt != 9'h1FF);
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    idle_read_a: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000)
        else $error("read data not zero");
    setup_back_a: assert property (reg_rd_i && reg_addr_i == shared_link_pkg::SETUP_ADDR
        |=> reg_rdata_o == $past(setup)) else $error("setup read back wrong");
    status_role_a: assert property (rd_st
        |=> reg_rdata_o[3] == $past(is_m) && reg_rdata_o[2] == $past(is_s))
        else $error("role bits wrong");
    master_range_a: assert property (rd_st && is_m |=> reg_rdata_o[1:0] == $past(code))
        else $error("range code wrong");
    up_mode_a: assert property ($rose(link_up_o) |-> is_m || is_s)
        else $error("link up while off");
    up_drop_a: assert property (wr_su && reg_wdata_i[15:13] != 3'h1 |=> !link_up_o)
        else $error("link up kept when off");
    tx_idle_a: assert property (off_cnt == 9'h1FF |-> link_tx_o)
        else $error("line busy while off");
    tx_start_a: assert property (wr_su && !is_m && !is_s && reg_wdata_i[15:13] == 3'h1
        |-> ##[1:64] !link_tx_o) else $error("no frame after setup");
endmodule
bind peer_shared_word_link peer_shared_word_link_chk peer_shared_word_link_chk_i (
    .core_clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .link_tx_o, .link_up_o);

// ### tb/link_peer_model.sv
`timescale 1ns/1ns
module link_peer_model (
    // clock
    input  wire logic core_clk_i,
    // serial line
    input  wire logic rx_i,
    output logic      tx_o
);
    // ********
    // peer controller
    // ********
    logic [15:0] mirror [64];
    logic [1:0]  seen_range;
    logic [23:0] sh;
    initial tx_o = 1'b1;
    // sample mid-bit; a bad stop bit drops the word, like the real receiver
    always begin
        @(negedge rx_i);
        repeat (8) @(posedge core_clk_i);
        for (int i = 0; i < 24; i++) begin
            repeat (16) @(posedge core_clk_i);
            sh = {rx_i, sh[23:1]};
        end
        repeat (16) @(posedge core_clk_i);
        if (rx_i) begin
            mirror[sh[21:16]] = sh[15:0];
            seen_range = sh[23:22];
        end
    end
    // one frame, payload lsb first; the line is left idle high
    task automatic send(input logic [1:0] r, input logic [5:0] a, input logic [15:0] d);
        logic [25:0] f;
        f = {1'b1, r, a, d, 1'b0};
        for (int i = 0; i < 26; i++) begin
            tx_o <= f[i];
            repeat (16) @(posedge core_clk_i);
        end
    endtask
endmodule

// ### tb/tb.sv
`timescale 1ns/1ns
module tb;
    localparam logic [15:0] su = shared_link_pkg::SETUP_ADDR;
    localparam logic [15:0] st = shared_link_pkg::STATUS_ADDR;
    logic        core_clk_i  = 1'b0;
    logic        rst_b_i     = 1'b0;
    logic [15:0] reg_addr_i  = 16'h0000;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic        reg_wr_i    = 1'b0;
    logic        reg_rd_i    = 1'b0;
    logic [15:0] reg_rdata_o;
    logic        link_rx_i;
    logic        link_tx_o;
    logic        link_up_o;
    int          n_fail      = 0;
    int          tests_run   = 0;
    int          cyc         = 0;
    peer_shared_word_link peer_shared_word_link_i (.core_clk_i, .rst_b_i, .reg_addr_i,
        .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .link_rx_i, .link_tx_o, .link_up_o);
    link_peer_model link_peer_model_i (.core_clk_i, .rx_i(link_tx_o), .tx_o(link_rx_i));
    // ********
    // clock, timeout, tasks
    // ********
    always #4 core_clk_i = ~core_clk_i;
    // tests need at most about 9700 cycles
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string s);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, s, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        @(posedge core_clk_i);
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] exp, input string s);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1 chk(reg_rdata_o, exp, s);
        @(posedge core_clk_i);
    endtask
    // the copy arrives within one sweep of the owner's words
    task automatic peer_has(input logic [5:0] a, input logic [15:0] exp, input string s);
        for (int n = 0; n < 8000 && link_peer_model_i.mirror[a] !== exp; n++)
            @(posedge core_clk_i);
        chk(link_peer_model_i.mirror[a], exp, s);
    endtask
    initial begin
        repeat (3) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        @(posedge core_clk_i);
        rd(su, shared_link_pkg::SETUP_RESET, "setup reset");
        for (int r = 0; r < 4; r++) begin
            wr(su, {4'h3, 4'(r), 8'h00});
            rd(st, {14'h0002, 2'(r % 3)}, "master range");
        end
        wr(su, 16'h3200);
        rd(su, 16'h3200, "setup back");
        wr(16'h0007, 16'h0707);
        link_peer_model_i.send(2'h2, 6'h09, 16'hBEEF);
        link_peer_model_i.send(2'h2, 6'h07, 16'h7777);
        repeat (2) @(posedge core_clk_i);
        chk({15'h0000, link_up_o}, 16'h0001, "link up");
        wr(16'h0009, 16'h1234);
        wr(16'h0003, 16'hA5C3);
        rd(16'h0009, 16'hBEEF, "partner word");
        rd(16'h0007, 16'h0707, "own word");
        peer_has(6'h03, 16'hA5C3, "master copy");
        chk({14'h0000, link_peer_model_i.seen_range}, 16'h0002, "range sent");
        $display("test master done");
        wr(su, 16'h2200);
        link_peer_model_i.send(2'h1, 6'h02, 16'h5A5A);
        repeat (2) @(posedge core_clk_i);
        rd(st, 16'h8005, "slave status");
        wr(16'h0002, 16'h0000);
        rd(16'h0002, 16'h5A5A, "slave partner word");
        wr(16'h0010, 16'hC0DE);
        link_peer_model_i.send(2'h1, 6'h10, 16'hDEAD);
        rd(16'h0010, 16'hC0DE, "slave own word");
        peer_has(6'h10, 16'hC0DE, "slave copy");
        $display("test slave done");
        wr(su, 16'h0000);
        #1 chk({15'h0000, link_up_o}, 16'h0000, "link down");
        repeat (520) @(posedge core_clk_i);
        chk({15'h0000, link_tx_o}, 16'h0001, "line idle");
        $display("test off done");
        stop_test();
    end
endmodule
